// ### src/dio_regs.vh
`ifndef DIO_REGS_VH
`define DIO_REGS_VH

// Bus geometry: byte address is four times the register index.
`define DIO_ADDR_W          8
`define DIO_IDX_LSB         2
`define DIO_IDX_MSB         5
`define DIO_IDX_LAST        4'hb

// Register indices; the byte address is the index times four.
`define DIO_IDX_GROUP0_FIRST_BYTE_PORT   4'h0
`define DIO_IDX_GROUP0_DIRECTION_CONFIG  4'h3
`define DIO_IDX_GROUP1_DIRECTION_CONFIG  4'h7
`define DIO_IDX_GROUP2_DIRECTION_CONFIG  4'hb

// Port selector inside a group (low two index bits).
`define DIO_SEL_FIRST       2'h0
`define DIO_SEL_SECOND      2'h1
`define DIO_SEL_SPLIT       2'h2
`define DIO_SEL_CONFIG      2'h3

// Configuration word fields, 1 selects input.
`define DIO_CFG_FIRST_BIT   4
`define DIO_CFG_HIGH_BIT    3
`define DIO_CFG_SECOND_BIT  1
`define DIO_CFG_LOW_BIT     0

// Force switch positions inside one group's switch nibble.
`define DIO_SW_FIRST        0
`define DIO_SW_SECOND       1
`define DIO_SW_LOW          2
`define DIO_SW_HIGH         3

// Default levels and directions.
`define DIO_DFLT_SOFT_BYTE  8'hff
`define DIO_DFLT_SOFT_NIB   4'hf
`define DIO_DFLT_FORCED_NIB 4'h0
`define DIO_DFLT_FORCED_BYTE 8'h00
`define DIO_DIR_INPUT       1'b1

// Cycles spent applying defaults, longer than the synchroniser delay.
`define DIO_INIT_CYCLES     3'h5

// Response codes.
`define DIO_RESP_OKAY       2'h0
`define DIO_RESP_DECERR     2'h3

`endif

// ### src/dio_sync.v
`timescale 1ns/100ps
// Three-stage synchroniser; a bit changes once stages two and three agree.
module dio_sync
#(
    parameter W = 1
)
(
    input  wire         sys_clk,
    input  wire         nrst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] stable
);

    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;

    // Stage one feeds stage two only, so a metastable value never spreads.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
            stage3 <= {W{1'b0}};
            stable <= {W{1'b0}};
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            stable <= (stage3 & ~(stage2 ^ stage3))
                      | (stable & (stage2 ^ stage3));
        end
    end

endmodule // dio_sync

// ### src/dio_group.v
`timescale 1ns/100ps
`include "dio_regs.vh"
// One mode-0 group: two byte ports and a split port of two nibbles.
module dio_group
(
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire        load_dflt,
    input  wire        wr_en,
    input  wire [1:0]  wr_sel,
    input  wire [7:0]  wr_data,
    input  wire [3:0]  force_sw,
    input  wire [23:0] pin_in,
    output wire [23:0] rd_bytes,
    output reg  [23:0] pin_out,
    output reg  [23:0] pin_oe
);

    reg [7:0] first_out;
    reg [7:0] second_out;
    reg [7:0] split_out;
    reg       dir_first;
    reg       dir_second;
    reg       dir_low;
    reg       dir_high;
    wire      drv_first;
    wire      drv_second;
    wire      drv_low;
    wire      drv_high;

    // A switch forces output whatever the stored direction bit says.
    assign drv_first  = force_sw[`DIO_SW_FIRST]  | ~dir_first;
    assign drv_second = force_sw[`DIO_SW_SECOND] | ~dir_second;
    assign drv_low    = force_sw[`DIO_SW_LOW]    | ~dir_low;
    assign drv_high   = force_sw[`DIO_SW_HIGH]   | ~dir_high;

    // Outputs read back their driven value, inputs the sampled pins.
    assign rd_bytes[7:0]   = drv_first  ? first_out       : pin_in[7:0];
    assign rd_bytes[15:8]  = drv_second ? second_out      : pin_in[15:8];
    assign rd_bytes[19:16] = drv_low    ? split_out[3:0]  : pin_in[19:16];
    assign rd_bytes[23:20] = drv_high   ? split_out[7:4]  : pin_in[23:20];

    // Latches and directions; defaults win, otherwise software writes.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            first_out  <= `DIO_DFLT_FORCED_BYTE;
            second_out <= `DIO_DFLT_FORCED_BYTE;
            split_out  <= `DIO_DFLT_FORCED_BYTE;
            dir_first  <= `DIO_DIR_INPUT;
            dir_second <= `DIO_DIR_INPUT;
            dir_low    <= `DIO_DIR_INPUT;
            dir_high   <= `DIO_DIR_INPUT;
        end
        else if (load_dflt)
        begin
            first_out  <= force_sw[`DIO_SW_FIRST] ?
                          `DIO_DFLT_FORCED_BYTE : `DIO_DFLT_SOFT_BYTE;
            second_out <= force_sw[`DIO_SW_SECOND] ?
                          `DIO_DFLT_FORCED_BYTE : `DIO_DFLT_SOFT_BYTE;
            split_out  <= {force_sw[`DIO_SW_HIGH] ?
                           `DIO_DFLT_FORCED_NIB : `DIO_DFLT_SOFT_NIB,
                           force_sw[`DIO_SW_LOW] ?
                           `DIO_DFLT_FORCED_NIB : `DIO_DFLT_SOFT_NIB};
            dir_first  <= `DIO_DIR_INPUT;
            dir_second <= `DIO_DIR_INPUT;
            dir_low    <= `DIO_DIR_INPUT;
            dir_high   <= `DIO_DIR_INPUT;
        end
        else if (wr_en)
        begin
            case (wr_sel)
                `DIO_SEL_FIRST:  first_out  <= wr_data;
                `DIO_SEL_SECOND: second_out <= wr_data;
                `DIO_SEL_SPLIT:  split_out  <= wr_data;
                default:
                begin
                    dir_first  <= wr_data[`DIO_CFG_FIRST_BIT];
                    dir_high   <= wr_data[`DIO_CFG_HIGH_BIT];
                    dir_second <= wr_data[`DIO_CFG_SECOND_BIT];
                    dir_low    <= wr_data[`DIO_CFG_LOW_BIT];
                end
            endcase
        end
    end

    // Pin drivers are registered so the top sees them straight from flops.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_out <= 24'h000000;
            pin_oe  <= 24'h000000;
        end
        else
        begin
            pin_out <= {split_out, second_out, first_out};
            pin_oe  <= {{4{drv_high}}, {4{drv_low}},
                        {8{drv_second}}, {8{drv_first}}};
        end
    end

endmodule // dio_group

// ### src/dio_top.v
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dio_regs.vh"
// How it works
// [RULE1] Nine byte ports, 72 lines, in three alike groups, plain mode 0.
// [RULE2] Each split port is two nibbles with separate direction bits.
// [RULE3] Reading an output port returns the value being driven.
// [RULE4] Config bit 4 first, 3 high, 1 second, 0 low; 1 is input.
// [RULE5] Group config words sit at indices 3, 7 and 11.
// [RULE6] An active force switch makes its port an output.
// [RULE7] A forced port ignores its config direction bit.
// [RULE8] A port turned to output drives its latch at once; here the enable follows one cycle after the config write lands.
// [RULE9] Software should load safe data before switching a port to output.
// [RULE10] Power-up or unretained reset: software ports input, level high.
// [RULE11] Power-up or unretained reset: forced ports drive low.
// [RULE12] Retained hot reset keeps every direction and output value.
// [RULE13] Retention covers forced ports and software ports alike.
// [RULE14] Power loss clears retained state; power-up applies defaults.
// [RULE15] Data writes latch output values; input reads return pin levels.
// [RULE16] Retention strap and hot reset inputs are apart from power reset.
module dio_top
(
    input  wire                  sys_clk,
    input  wire                  nrst,
    input  wire                  hot_reset_n,
    input  wire                  retention_strap,
    input  wire [3:0]            group0_force_switches,
    input  wire [3:0]            group1_force_switches,
    input  wire [3:0]            group2_force_switches,
    input  wire [71:0]           io_in,
    output wire [71:0]           io_out,
    output wire [71:0]           io_oe,
    input  wire [`DIO_ADDR_W-1:0] s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [`DIO_ADDR_W-1:0] s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    localparam [2:0] ST_INIT = 3'b001;
    localparam [2:0] ST_RUN  = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    reg  [2:0]             state;
    reg  [2:0]             next_state;
    reg  [2:0]             init_cnt;
    reg  [2:0]             next_init_cnt;
    reg  [`DIO_ADDR_W-1:0] wr_addr;
    reg  [7:0]             wr_byte;
    reg                    wr_lane0;
    reg  [7:0]             rd_byte;
    reg                    rd_ok;
    wire [85:0]            sync_raw;
    wire [85:0]            sync_out;
    wire [71:0]            pins;
    wire [11:0]            force_all;
    wire                   strap_on;
    wire                   hot_req;
    wire                   load_dflt;
    wire [71:0]            rd_all;
    wire                   wr_fire;
    wire [3:0]             wr_idx;
    wire                   wr_mapped;
    wire [3:0]             rd_idx;
    wire                   rd_mapped;
    wire [2:0]             grp_wr_en;

    ////////////////////////////////////////////////////////////////////////
    // Every pin-side input is synchronised in one bank of three stages.

    assign sync_raw = {~hot_reset_n, retention_strap,
                       group2_force_switches, group1_force_switches,
                       group0_force_switches, io_in};

    dio_sync
    #(
        .W (86)
    )
    u_sync
    (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in (sync_raw),
        .stable   (sync_out)
    );

    // Split the synchronised bank back into its meanings.
    assign pins      = sync_out[71:0];
    assign force_all = sync_out[83:72];
    assign strap_on  = sync_out[84];
    assign hot_req   = sync_out[85];                 // see [RULE16]

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer.
    // The power reset nrst always lands in INIT, so nothing survives a
    // power loss. A hot reset lands in HOLD when the strap is fitted,
    // which freezes every port, and in INIT otherwise. INIT lasts long
    // enough for the switch levels to pass the synchroniser, because the
    // forced-low defaults depend on them.

    assign load_dflt = state[0];                      // see [RULE14]

    always @*
    begin
        next_state    = state;
        next_init_cnt = init_cnt;
        case (state)
            ST_INIT:
            begin
                if (init_cnt != `DIO_INIT_CYCLES)
                begin
                    next_init_cnt = init_cnt + 3'h1;
                end
                else if (!hot_req)
                begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (hot_req && strap_on)
                begin
                    next_state = ST_HOLD;             // see [RULE12]
                end
                else if (hot_req)
                begin
                    next_state    = ST_INIT;          // see [RULE10]
                    next_init_cnt = 3'h0;
                end
            end
            ST_HOLD:
            begin
                // Latches and directions stay put, forced ports included.
                if (!hot_req)
                begin
                    next_state = ST_RUN;              // see [RULE13]
                end
            end
            default:
            begin
                next_state    = ST_INIT;
                next_init_cnt = 3'h0;
            end
        endcase
    end

    // State and counter registers.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state    <= ST_INIT;
            init_cnt <= 3'h0;
        end
        else
        begin
            state    <= next_state;
            init_cnt <= next_init_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channel.
    // Address and data are each taken once and held until the response is
    // handed over; the write itself waits for the run state, so a write
    // that arrives during a reset phase is stalled, not lost.

    assign wr_fire   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid
                       & state[1];
    assign wr_idx    = wr_addr[`DIO_IDX_MSB:`DIO_IDX_LSB];
    assign wr_mapped = (wr_addr[`DIO_ADDR_W-1:`DIO_IDX_MSB+1] == 2'h0)
                       && (wr_idx <= `DIO_IDX_LAST);

    // Address handshake.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_awready <= 1'b1;
            wr_addr       <= {`DIO_ADDR_W{1'b0}};
        end
        else if (s_axi_awready && s_axi_awvalid)
        begin
            s_axi_awready <= 1'b0;
            wr_addr       <= s_axi_awaddr;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_awready <= 1'b1;
        end
    end

    // Data handshake; only byte lane 0 carries register bits.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_wready <= 1'b1;
            wr_byte      <= 8'h00;
            wr_lane0     <= 1'b0;
        end
        else if (s_axi_wready && s_axi_wvalid)
        begin
            s_axi_wready <= 1'b0;
            wr_byte      <= s_axi_wdata[7:0];
            wr_lane0     <= s_axi_wstrb[0];
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_wready <= 1'b1;
        end
    end

    // Response; an index outside 0 to 11 gets a decode error.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DIO_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `DIO_RESP_OKAY : `DIO_RESP_DECERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Group strobes: index bits 3:2 pick the group, bits 1:0 the port.
    // A write with lane 0 disabled is answered but changes nothing.
    assign grp_wr_en[0] = wr_fire & wr_mapped & wr_lane0
                          & (wr_idx[3:2] == 2'h0);    // see [RULE5]
    assign grp_wr_en[1] = wr_fire & wr_mapped & wr_lane0
                          & (wr_idx[3:2] == 2'h1);
    assign grp_wr_en[2] = wr_fire & wr_mapped & wr_lane0
                          & (wr_idx[3:2] == 2'h2);

    ////////////////////////////////////////////////////////////////////////
    // Port groups.
    // Each group keeps its own latches and directions; the pin_out and
    // pin_oe outputs of these instances are the registered pin drivers. Since the enables
    // follow the direction one cycle later, a port switched to output
    // shows its latched value one cycle after the config write lands.

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_group
            dio_group u_group                         // see [RULE1]
            (
                .sys_clk   (sys_clk),
                .nrst      (nrst),
                .load_dflt (load_dflt),               // see [RULE11]
                .wr_en     (grp_wr_en[g]),            // see [RULE15]
                .wr_sel    (wr_idx[1:0]),             // see [RULE4]
                .wr_data   (wr_byte),
                .force_sw  (force_all[g*4 +: 4]),     // see [RULE6]
                .pin_in    (pins[g*24 +: 24]),
                .rd_bytes  (rd_all[g*24 +: 24]),      // see [RULE3]
                .pin_out   (io_out[g*24 +: 24]),      // see [RULE8]
                .pin_oe    (io_oe[g*24 +: 24])        // see [RULE7]
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read channel.
    // A read is answered in the cycle after it is taken, in any state.
    // The config words are write only and read back as zero; nibble
    // halves of a split port each follow their own direction.

    assign rd_idx    = s_axi_araddr[`DIO_IDX_MSB:`DIO_IDX_LSB];
    assign rd_mapped = (s_axi_araddr[`DIO_ADDR_W-1:`DIO_IDX_MSB+1] == 2'h0)
                       && (rd_idx <= `DIO_IDX_LAST);

    // Read data selection.
    always @*
    begin
        rd_byte = 8'h00;
        rd_ok   = rd_mapped;
        case (rd_idx[1:0])
            `DIO_SEL_FIRST:  rd_byte = rd_all[rd_idx[3:2]*24 +: 8];
            `DIO_SEL_SECOND: rd_byte = rd_all[rd_idx[3:2]*24 + 8 +: 8];
            `DIO_SEL_SPLIT:  rd_byte = rd_all[rd_idx[3:2]*24 + 16 +: 8];
            default:         rd_byte = 8'h00;
        endcase
        if (!rd_mapped)
        begin
            rd_byte = 8'h00;
        end
    end

    // Read handshake and data register.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DIO_RESP_OKAY;
        end
        else if (s_axi_arready && s_axi_arvalid)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};   // see [RULE2]
            s_axi_rresp   <= rd_ok ? `DIO_RESP_OKAY : `DIO_RESP_DECERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule // dio_top

// ### testbench/dio_properties.sv
`timescale 1ns/100ps
`include "dio_regs.vh"
// Port-level checks of the digital I/O block.
module dio_chk
(
    input wire        sys_clk,
    input wire        nrst,
    input wire        hot_reset_n,
    input wire        retention_strap,
    input wire [3:0]  group0_force_switches,
    input wire [3:0]  group2_force_switches,
    input wire [71:0] io_out,
    input wire [71:0] io_oe,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // Group 0 config write, with its first port not forced.
    sequence s_cfg0(logic d);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 8'h0c && s_axi_wstrb[0]
        && !group0_force_switches[0] && s_axi_wdata[4] == d;
    endsequence
    // The write completes once its response rises.
    sequence s_done;
        ##[1:3] $rose(s_axi_bvalid);
    endsequence

    a_cfg_out: assert property (s_cfg0(1'b0) |->
        s_done ##[1:2] io_oe[7:0] == 8'hff) else $error("port not output");
    a_cfg_in: assert property (s_cfg0(1'b1) |->
        s_done ##[1:2] io_oe[7:0] == 8'h00) else $error("port not input");
    a_force_out: assert property (
        (group2_force_switches[3])[*8] |->
        ##2 io_oe[71:68] == 4'hf) else $error("forced nibble not output");
    a_read_back: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h00 && io_oe[7:0] == 8'hff && s_axi_awready
        |=> s_axi_rvalid && s_axi_rdata == {24'h0, io_out[7:0]})
        else $error("read back differs from driven value");
    a_cfg_rdzero: assert property (
        s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h0c |=> s_axi_rvalid && s_axi_rdata == 32'h0
        && s_axi_rresp == 2'h0) else $error("config read not zero");
    a_rd_decerr: assert property (s_axi_arvalid && s_axi_arready
        && (s_axi_araddr[7:6] != 2'h0 || s_axi_araddr[5:2] > 4'hb)
        |=> s_axi_rresp == 2'h3) else $error("unmapped read not refused");
    a_wr_decerr: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready && s_axi_awaddr[7:6] != 2'h0
        |-> ##[1:3] s_axi_bvalid && s_axi_bresp == 2'h3)
        else $error("unmapped write not refused");
    a_hold_keeps: assert property (
        (!hot_reset_n && retention_strap)[*8]
        |-> $stable(io_oe) && $stable(io_out)) else $error("held state moved");
    a_dflt_unret: assert property (
        (!hot_reset_n && !retention_strap
        && group0_force_switches == 4'h2)[*8] |-> ##2
        io_oe[15:0] == 16'hff00 && io_out[15:0] == 16'h00ff)
        else $error("defaults not applied");
endmodule // dio_chk

bind dio_top dio_chk u_chk (.*);

// ### testbench/dio_field.sv
`timescale 1ns/100ps
// Field devices: a line the card drives reads back as driven; any other
// line carries the device level set by the bench, never a stale value.
module dio_field
(
    input  wire logic [71:0] io_out,
    input  wire logic [71:0] io_oe,
    input  wire logic [71:0] field_val,
    output wire logic [71:0] io_in
);
    // Resolve each wire from both parties.
    assign io_in = (io_oe & io_out) | (~io_oe & field_val);
endmodule // dio_field

// ### testbench/testbench.sv
`timescale 1ns/100ps
`include "dio_regs.vh"
module testbench;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        hot_reset_n = 1'b1;
    logic        retention_strap = 1'b0;
    logic [3:0]  group0_force_switches = 4'h2;
    logic [3:0]  group1_force_switches = 4'h0;
    logic [3:0]  group2_force_switches = 4'h8;
    logic [71:0] io_in, io_out, io_oe;
    logic [71:0] fld = 72'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          fails = 0, compares = 0;
    logic [31:0] seed = 32'd46283;
    logic [1:0]  qb [$];
    logic [33:0] qr [$];
    logic [33:0] re;
    logic [23:0] goe [3], glat [3];
    logic [7:0]  cfgs [4] = '{8'he0, 8'h1b, 8'h12, 8'h09};

    dio_top dut (.*);
    dio_field field (.io_out(io_out), .io_oe(io_oe), .field_val(fld),
                     .io_in(io_in));

    always #2 sys_clk = ~sys_clk;

    task end_sim();
        $display("Compares %0d, fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [143:0] s, input logic [143:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Direction mask of one group; a set bit makes that port drive.
    function logic [23:0] fm(input logic [3:0] f);
        return {{4{f[3]}}, {4{f[2]}}, {8{f[1]}}, {8{f[0]}}};
    endfunction

    ////////////////////////////////
    // Bus master: ready and valid are looked at mid-cycle, where settled.
    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        bit pa, pw, pb;
        qb.push_back(r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge sys_clk);
            pa = s_axi_awready;
            pw = s_axi_wready;
            pb = s_axi_bvalid;
            @(posedge sys_clk);
            if (pa) s_axi_awvalid <= 1'b0;
            if (pw) s_axi_wvalid <= 1'b0;
        end
        while (!pb);
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [33:0] e);
        bit pa, pb;
        qr.push_back(e);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge sys_clk);
            pa = s_axi_arready;
            pb = s_axi_rvalid;
            @(posedge sys_clk);
            if (pa) s_axi_arvalid <= 1'b0;
        end
        while (!pb);
        s_axi_rready <= 1'b0;
    endtask

    // Each response is matched with the oldest note of its channel.
    always @(posedge sys_clk)
    begin
        if (s_axi_bvalid && s_axi_bready)
            chk(s_axi_bresp, qb.pop_front());
        if (s_axi_rvalid && s_axi_rready)
        begin
            re = qr.pop_front();
            chk({s_axi_rresp, re[33] ? 32'h0 : s_axi_rdata},
                re);
        end
    end

    // One group: random switches and pins, safe data first, then config.
    task round(input logic [1:0] g, input logic [7:0] c);
        logic [31:0] r;
        logic [23:0] lat, oe, v;
        r = xs();
        lat = r[31:8];
        fld <= {r[7:0], xs(), xs()};
        if (g == 2'h0) group0_force_switches <= r[3:0] & 4'he;
        if (g == 2'h1) group1_force_switches <= r[3:0];
        if (g == 2'h2) group2_force_switches <= r[3:0];
        for (int k = 0; k < 3; k++)
            wr({2'b00, g, k[1:0], 2'b00}, lat[k*8+:8], 2'h0);
        wr({2'b00, g, 4'hc}, c, 2'h0);
        repeat (10) @(posedge sys_clk);
        oe = fm((r[3:0] & (g == 2'h0 ? 4'he : 4'hf))
                | {~c[3], ~c[0], ~c[1], ~c[4]});
        v = (oe & lat) | (~oe & fld[g*24+:24]);
        @(negedge sys_clk);
        chk(io_oe[g*24+:24], oe);
        chk(io_out[g*24+:24] & oe, lat & oe);
        for (int k = 0; k < 3; k++)
            rd({2'b00, g, k[1:0], 2'b00}, {26'h0, v[k*8+:8]});
        goe[g] = oe;
        glat[g] = lat;
    endtask

    task dflt();
        logic [71:0] m;
        m = {fm(group2_force_switches), fm(group1_force_switches),
             fm(group0_force_switches)};
        @(negedge sys_clk);
        chk({io_oe, io_out}, {m, ~m});
    endtask

    task kept();
        logic [71:0] m;
        m = {goe[2], goe[1], goe[0]};
        @(negedge sys_clk);
        chk({io_oe, io_out & m},
            {m, {glat[2], glat[1], glat[0]} & m});
    endtask

    // Hot reset: the strap settles before the reset line falls.
    task hot(input logic s);
        retention_strap <= s;
        repeat (8) @(posedge sys_clk);
        hot_reset_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        if (s) kept(); else dflt();
        @(posedge sys_clk);
        hot_reset_n <= 1'b1;
        repeat (16) @(posedge sys_clk);
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (16) @(posedge sys_clk);
        dflt();
        rd(8'h0c, 34'h0);
        rd(8'h30, {2'h3, 32'h0});
        wr(8'hc0, 8'h00, 2'h3);
        // A write without lane 0 is answered but leaves the forced latch.
        s_axi_wstrb <= 4'he;
        wr(8'h04, 8'h55, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(8'h04, 34'h0);
        for (int g = 0; g < 3; g++)
            foreach (cfgs[i]) round(g[1:0], cfgs[i]);
        hot(1'b1);
        kept();
        group0_force_switches <= 4'h2;
        hot(1'b0);
        dflt();
        round(2'h0, 8'he0);
        retention_strap <= 1'b1;
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (16) @(posedge sys_clk);
        dflt();
        end_sim();
    end

    // A hang ends the run as a failure.
    initial
    begin
        #200000;
        fails++;
        end_sim();
    end
endmodule // testbench
